//--- hw/eac_pkg.sv
// Constants shared by the data-nonvolatile-memory access controller.
// Assumes an 8-bit CPU register port and a byte-wide storage array.
//
// Notes on behaviour
// RL1 - Mode field picks erase+write, erase, or write.
// RL2 - Mode writes ignored while write strobe set.
// RL3 - Reset clears mode unless programming still runs.
// RL4 - Ready interrupt level while strobe reads zero.
// RL5 - No ready interrupt during write or self-programming.
// RL6 - Hardware clears write arm four cycles later.
// RL7 - Strobe starts write only when arm set.
// RL8 - Software arms, then strobes within four cycles.
// RL9 - No programming start during flash self-programming.
// RL10 - Hardware clears write strobe when timing ends.
// RL11 - Write strobe stalls CPU two cycles.
// RL12 - Read strobe loads byte, stalls four cycles.
// RL13 - During write: no read, address frozen.
// RL14 - Software polls strobe zero before reading.
// RL15 - Write period is 26368 RC oscillator cycles.
// RL16 - Ten-bit linear byte address, up to 1023.
// RL17 - Data register feeds writes, receives reads.
// RL18 - Reserved address and control bits read zero.
// RL19 - Software keeps interrupts off during write sequence.
// RL20 - Bit set/clear only 0x00-0x1f, one bit.
// RL21 - Registers also at I/O address plus 0x20.
// RL22 - Write runs on to completion through reset.
// RL23 - Reserved mode code starts no programming.
package eac_pkg;

  // I/O space offsets
  localparam logic [7:0] OFS_CTRL = 8'h1f;
  localparam logic [7:0] OFS_DATA = 8'h20;
  localparam logic [7:0] OFS_ADDR_LO = 8'h21;
  localparam logic [7:0] OFS_ADDR_HI = 8'h22;
  // Data-space view sits this far above the I/O address
  localparam logic [7:0] DSPACE_OFS = 8'h20;
  // Highest register reachable by single-bit set and clear
  localparam logic [7:0] BITOP_LAST = 8'h1f;

  // Control register field positions
  localparam int CTRL_READ = 0;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_RIE = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_MODE_HI = 5;

  // Programming mode codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;

  // Cycle counts on the CPU clock
  localparam logic [2:0] ARM_CYC = 3'h4;
  localparam logic [2:0] WR_STALL_CYC = 3'h2;
  localparam logic [2:0] RD_STALL_CYC = 3'h4;

  // Programming times, in microseconds, as typical figures
  localparam int ATOMIC_TIME_US = 3400;
  localparam int SPLIT_TIME_US = 1800;
  // Oscillator cycles for one full write and for a split step
  localparam int ATOMIC_RC_CYC = 26368;
  localparam int SPLIT_RC_CYC = ATOMIC_RC_CYC * SPLIT_TIME_US
                                / ATOMIC_TIME_US;
  localparam int RC_CNT_W = 15;

endpackage : eac_pkg

//--- hw/eac_tmr_if.sv
// Link between the register logic and the programming timer.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface eac_tmr_if #(
  parameter int CNT_W = 15
);
  logic start; // Pulse: begin a timed operation
  logic [CNT_W-1:0] cycles; // Oscillator cycles to run
  logic busy; // Level: operation in progress
  logic done; // Pulse: operation just ended

  modport ctrl (output start, output cycles, input busy, input done);
  modport tmr (input start, input cycles, output busy, output done);
endinterface : eac_tmr_if
`default_nettype wire

//--- hw/eac_prog_timer.sv
// Self-timed programming counter, paced by oscillator ticks.
// Assumes rc_tick_i is a one-cycle enable synchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module eac_prog_timer #(
  parameter int CNT_W = 15
)(
  input wire logic sys_clk_i,
  input wire logic por_nrst_i,
  input wire logic rc_tick_i,
  eac_tmr_if.tmr tmr
);

  logic [CNT_W-1:0] cnt_q; // Oscillator cycles left
  logic busy_q; // Operation running
  logic done_q; // End pulse
  logic last_w; // Final tick arriving

  assign last_w = busy_q && rc_tick_i && (cnt_q == CNT_W'(1));
  assign tmr.busy = busy_q;
  assign tmr.done = done_q;

  // Only power-on reset: a system reset must not abort a write
  always_ff @(posedge sys_clk_i or negedge por_nrst_i)
  begin
    if (!por_nrst_i)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= last_w; // RL10
      if (tmr.start && !busy_q)
      begin
        cnt_q <= tmr.cycles; // RL15
        busy_q <= 1'b1;
      end
      else if (last_w)
      begin
        cnt_q <= '0;
        busy_q <= 1'b0; // RL22
      end
      else if (busy_q && rc_tick_i)
      begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

endmodule : eac_prog_timer
`default_nettype wire

//--- hw/eac_ctrl.sv
// Register front end for the byte-wide data storage array.
// Assumes a CPU port with one-cycle read/write and bit-op pulses,
// and an array that answers arr_rdata_i combinationally.
`timescale 1ns/100ps
`default_nettype none
module eac_ctrl #(
  parameter int ADDR_W = 10,
  parameter int ATOMIC_CYC = eac_pkg::ATOMIC_RC_CYC,
  parameter int SPLIT_CYC = eac_pkg::SPLIT_RC_CYC
)(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic por_nrst_i,
  input wire logic rc_tick_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_dspace_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_bset_i,
  input wire logic cpu_bclr_i,
  input wire logic [2:0] cpu_bit_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_stall_o,
  input wire logic global_irq_en_i,
  input wire logic self_prog_active_i,
  output logic ready_irq_o,
  output logic [ADDR_W-1:0] arr_addr_o,
  output logic [7:0] arr_wdata_o,
  output logic [1:0] arr_mode_o,
  output logic arr_start_o,
  output logic arr_busy_o,
  input wire logic [7:0] arr_rdata_i
);

  localparam int CW = eac_pkg::RC_CNT_W;
  localparam int HI_W = ADDR_W - 8; // Address bits held in high byte

  // Timer link
  eac_tmr_if #(.CNT_W(CW)) tmr_if ();

  // Register state on the system reset
  logic [ADDR_W-1:0] addr_q; // Byte address
  logic [7:0] buf_q; // Data register
  logic rie_q; // Ready interrupt enable
  logic arm_q; // Write arm
  logic [2:0] arm_cnt_q; // Cycles since arm was set
  logic [2:0] stall_cnt_q; // CPU stall cycles left
  logic [7:0] rdata_q; // Registered read answer
  // State that must outlive a system reset
  logic [1:0] mode_q; // Programming mode
  logic [ADDR_W-1:0] prog_addr_q; // Address latched at start
  logic [7:0] prog_data_q; // Byte latched at start
  logic [1:0] prog_mode_q; // Mode latched at start
  logic start_q; // Start pulse to the array

  // Address decode, folding the data-space view back to I/O
  logic [7:0] io_addr_w;
  logic any_acc_w;
  logic bitop_w;
  logic hit_ctrl_w;
  logic hit_data_w;
  logic hit_lo_w;
  logic hit_hi_w;

  assign io_addr_w = cpu_dspace_i ? cpu_addr_i - eac_pkg::DSPACE_OFS
                                  : cpu_addr_i; // RL21
  // Bit ops only reach the low 32 I/O registers
  assign bitop_w = (cpu_bset_i || cpu_bclr_i) && !cpu_dspace_i
                   && (io_addr_w <= eac_pkg::BITOP_LAST); // RL20
  assign any_acc_w = cpu_wr_i || bitop_w;
  assign hit_ctrl_w = any_acc_w && (io_addr_w == eac_pkg::OFS_CTRL);
  assign hit_data_w = any_acc_w && (io_addr_w == eac_pkg::OFS_DATA);
  assign hit_lo_w = any_acc_w && (io_addr_w == eac_pkg::OFS_ADDR_LO);
  assign hit_hi_w = any_acc_w && (io_addr_w == eac_pkg::OFS_ADDR_HI);

  // Write mask: a full write touches every bit, a bit op just one
  logic [7:0] wmask_w;
  logic [7:0] wval_w;
  assign wmask_w = cpu_wr_i ? 8'hff : (8'h01 << cpu_bit_i); // RL20
  assign wval_w = cpu_wr_i ? cpu_wdata_i
                           : (cpu_bset_i ? 8'hff : 8'h00);

  // Control register view
  logic busy_w;
  logic [7:0] ctrl_rd_w;
  assign busy_w = tmr_if.busy; // Write strobe reads as busy
  assign ctrl_rd_w = {2'h0, mode_q, rie_q, arm_q, busy_w,
                      1'b0}; // RL18

  // Field write enables taken from the mask
  logic wr_mode_lo_w;
  logic wr_mode_hi_w;
  logic wr_rie_w;
  logic wr_arm_w;
  logic set_strobe_w;
  logic set_read_w;
  logic [1:0] mode_nx_w;
  assign wr_mode_lo_w = hit_ctrl_w && wmask_w[eac_pkg::CTRL_MODE_LO];
  assign wr_mode_hi_w = hit_ctrl_w && wmask_w[eac_pkg::CTRL_MODE_HI];
  assign wr_rie_w = hit_ctrl_w && wmask_w[eac_pkg::CTRL_RIE];
  assign wr_arm_w = hit_ctrl_w && wmask_w[eac_pkg::CTRL_ARM];
  assign set_strobe_w = hit_ctrl_w && wmask_w[eac_pkg::CTRL_STROBE]
                        && wval_w[eac_pkg::CTRL_STROBE];
  assign set_read_w = hit_ctrl_w && wmask_w[eac_pkg::CTRL_READ]
                      && wval_w[eac_pkg::CTRL_READ];
  assign mode_nx_w = {wr_mode_hi_w ? wval_w[eac_pkg::CTRL_MODE_HI]
                                   : mode_q[1],
                      wr_mode_lo_w ? wval_w[eac_pkg::CTRL_MODE_LO]
                                   : mode_q[0]};

  // Start condition for a programming operation
  logic start_w;
  logic rd_go_w;
  assign start_w = set_strobe_w && arm_q && !busy_w // RL7
                   && !self_prog_active_i // RL9
                   && (mode_q != eac_pkg::MODE_RSVD); // RL23
  // Reads are refused while a write runs
  assign rd_go_w = set_read_w && !busy_w; // RL13

  // Timer load per mode: split steps are shorter
  assign tmr_if.start = start_w;
  assign tmr_if.cycles = (mode_q == eac_pkg::MODE_ATOMIC)
                         ? CW'(ATOMIC_CYC) : CW'(SPLIT_CYC); // RL1

  // Programming timer, reset only at power-on
  eac_prog_timer #(.CNT_W(CW)) u_timer (
    .sys_clk_i(sys_clk_i),
    .por_nrst_i(por_nrst_i),
    .rc_tick_i(rc_tick_i),
    .tmr(tmr_if)
  );

  // Address register, frozen while programming
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      addr_q <= '0;
    end
    else if (!busy_w) // RL13
    begin
      if (hit_lo_w)
      begin
        // Unmasked bits keep their old value
        addr_q[7:0] <= (addr_q[7:0] & ~wmask_w) | (wval_w & wmask_w);
      end
      else if (hit_hi_w)
      begin
        addr_q[ADDR_W-1:8] <= (addr_q[ADDR_W-1:8] & ~wmask_w[HI_W-1:0])
                              | (wval_w[HI_W-1:0] & wmask_w[HI_W-1:0]);
      end
    end
  end

  // Data register: CPU writes, array reads land here
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      buf_q <= eac_pkg::BYTE_RST;
    end
    else if (rd_go_w)
    begin
      buf_q <= arr_rdata_i; // RL12 RL17
    end
    else if (hit_data_w)
    begin
      buf_q <= (buf_q & ~wmask_w) | (wval_w & wmask_w);
    end
  end

  // Enable and arm bits; arm drops on its own after four cycles
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rie_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= '0;
    end
    else
    begin
      if (wr_rie_w)
      begin
        rie_q <= wval_w[eac_pkg::CTRL_RIE];
      end
      if (wr_arm_w)
      begin
        // Writing one restarts the window
        arm_q <= wval_w[eac_pkg::CTRL_ARM];
        arm_cnt_q <= '0;
      end
      else if (arm_q && (arm_cnt_q == eac_pkg::ARM_CYC - 3'h1))
      begin
        arm_q <= 1'b0; // RL6
        arm_cnt_q <= '0;
      end
      else if (arm_q)
      begin
        arm_cnt_q <= arm_cnt_q + 3'h1;
      end
    end
  end

  // CPU stall counter; a write start wins over a read in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stall_cnt_q <= '0;
    end
    else if (start_w)
    begin
      stall_cnt_q <= eac_pkg::WR_STALL_CYC; // RL11
    end
    else if (rd_go_w)
    begin
      stall_cnt_q <= eac_pkg::RD_STALL_CYC; // RL12
    end
    else if (stall_cnt_q != 3'h0)
    begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
    end
  end
  assign cpu_stall_o = (stall_cnt_q != 3'h0);

  // Read mux, registered; unmapped addresses answer zero
  logic [7:0] rd_mux_w;
  always_comb
  begin
    rd_mux_w = 8'h00;
    if (io_addr_w == eac_pkg::OFS_CTRL)
      rd_mux_w = ctrl_rd_w;
    else if (io_addr_w == eac_pkg::OFS_DATA)
      rd_mux_w = buf_q;
    else if (io_addr_w == eac_pkg::OFS_ADDR_LO)
      rd_mux_w = addr_q[7:0];
    else if (io_addr_w == eac_pkg::OFS_ADDR_HI)
      rd_mux_w = {{(16 - ADDR_W){1'b0}}, addr_q[ADDR_W-1:8]}; // RL18 RL16
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_q <= eac_pkg::BYTE_RST;
    end
    else if (cpu_rd_i)
    begin
      rdata_q <= rd_mux_w;
    end
  end
  assign cpu_rdata_o = rdata_q;

  // Mode and latched operation survive system reset while busy
  always_ff @(posedge sys_clk_i or negedge por_nrst_i)
  begin
    if (!por_nrst_i)
    begin
      mode_q <= eac_pkg::MODE_RST;
      prog_addr_q <= '0;
      prog_data_q <= eac_pkg::BYTE_RST;
      prog_mode_q <= eac_pkg::MODE_RST;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= start_w;
      if (!nrst_i && !busy_w)
      begin
        mode_q <= eac_pkg::MODE_RST; // RL3
      end
      else if (nrst_i && !busy_w) // RL2
      begin
        mode_q <= mode_nx_w; // RL1
      end
      if (start_w)
      begin
        // Hold the target so a reset cannot disturb the write
        prog_addr_q <= addr_q; // RL22
        prog_data_q <= buf_q; // RL17
        prog_mode_q <= mode_q;
      end
    end
  end

  // Array side: write target while busy, else the live address
  assign arr_addr_o = busy_w ? prog_addr_q : addr_q;
  assign arr_wdata_o = prog_data_q;
  assign arr_mode_o = prog_mode_q;
  assign arr_start_o = start_q;
  assign arr_busy_o = busy_w;

  // Level interrupt whenever the array is idle, no self-programming runs, and both enables are set
  assign ready_irq_o = rie_q && global_irq_en_i && !busy_w // RL4
                       && !self_prog_active_i; // RL5

endmodule : eac_ctrl
`default_nettype wire

//--- bench/eac_ctrl_sva.sv
// Port checks for the storage access register front end.
// Assumes binding into eac_ctrl with the power-on reset held high.
`timescale 1ns/100ps
`default_nettype none
module eac_ctrl_sva #(
  parameter int ADDR_W = 10,
  parameter int ATOMIC_CYC = eac_pkg::ATOMIC_RC_CYC,
  parameter int SPLIT_CYC = eac_pkg::SPLIT_RC_CYC
)(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic rc_tick_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic cpu_dspace_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic [7:0] cpu_rdata_o,
  input wire logic cpu_stall_o,
  input wire logic global_irq_en_i,
  input wire logic self_prog_active_i,
  input wire logic ready_irq_o,
  input wire logic [ADDR_W-1:0] arr_addr_o,
  input wire logic [1:0] arr_mode_o,
  input wire logic arr_start_o,
  input wire logic arr_busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Control byte write through either address view
  wire ctl_wr = cpu_wr_i && (cpu_dspace_i ? cpu_addr_i == 8'h3f
    : cpu_addr_i == eac_pkg::OFS_CTRL);
  // Lone read strobe while idle
  wire rd_go = ctl_wr && cpu_wdata_i == 8'h01 && !arr_busy_o;
  // Expected ticks for the latched mode
  wire [15:0] tk_n = (arr_mode_o == 2'h0) ? 16'(ATOMIC_CYC)
    : 16'(SPLIT_CYC);
  // Ticks seen in this busy period; start edge is uncertain by one
  logic [15:0] tk_q;
  always_ff @(posedge sys_clk_i)
    tk_q <= arr_busy_o ? tk_q + 16'(rc_tick_i) : 16'h0;
  sequence s_wr_hold;
    cpu_stall_o [*2] ##1 !cpu_stall_o;
  endsequence
  sequence s_rd_hold;
    cpu_stall_o [*4] ##1 !cpu_stall_o;
  endsequence
  chk_wr_stall: assert property ($rose(arr_busy_o) |-> s_wr_hold)
    else $error("write stall length wrong");
  chk_rd_stall: assert property (rd_go |=> s_rd_hold)
    else $error("read stall length wrong");
  // Start pulse and busy rise on the same edge
  chk_start_pulse: assert property ($rose(arr_busy_o) |->
    arr_start_o ##1 !arr_start_o)
    else $error("array start pulse wrong");
  chk_busy_cause: assert property ($rose(arr_busy_o) |->
    $past(ctl_wr && cpu_wdata_i[1] && !self_prog_active_i))
    else $error("busy without a strobe");
  chk_busy_len: assert property ($fell(arr_busy_o) |->
    tk_q inside {[tk_n - 16'h1 : tk_n]})
    else $error("programming length wrong");
  chk_irq_gate: assert property (ready_irq_o |->
    global_irq_en_i && !arr_busy_o && !self_prog_active_i)
    else $error("ready interrupt while blocked");
  chk_addr_hold: assert property (arr_busy_o && $past(arr_busy_o)
    |-> $stable(arr_addr_o))
    else $error("address moved while busy");
  chk_mode_hold: assert property (arr_busy_o && $past(arr_busy_o)
    |-> $stable(arr_mode_o))
    else $error("mode moved while busy");
  chk_rdata_hold: assert property (!$past(cpu_rd_i)
    |-> $stable(cpu_rdata_o))
    else $error("read data moved without a read");
endmodule : eac_ctrl_sva
bind eac_ctrl eac_ctrl_sva #(.ADDR_W(ADDR_W), .ATOMIC_CYC(ATOMIC_CYC),
  .SPLIT_CYC(SPLIT_CYC)) eac_ctrl_sva_i (.sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i), .rc_tick_i(rc_tick_i), .cpu_addr_i(cpu_addr_i),
  .cpu_dspace_i(cpu_dspace_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
  .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
  .cpu_stall_o(cpu_stall_o), .global_irq_en_i(global_irq_en_i),
  .self_prog_active_i(self_prog_active_i), .ready_irq_o(ready_irq_o),
  .arr_addr_o(arr_addr_o), .arr_mode_o(arr_mode_o),
  .arr_start_o(arr_start_o), .arr_busy_o(arr_busy_o));
`default_nettype wire

//--- bench/eac_nv_model.sv
// Behavioural byte array on the far side of the controller.
// Assumes one clock; cells are blank (zero) at time zero.
`timescale 1ns/100ps
`default_nettype none
module eac_nv_model (
  input wire logic sys_clk_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] mode_i,
  input wire logic start_i,
  input wire logic busy_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [1024]; // Cells
  logic [9:0] a_q; // Latched target
  logic [7:0] d_q; // Latched byte
  logic [1:0] m_q; // Latched mode
  logic busy_q; // Busy seen last cycle
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Commit only when timing ends, so early reads see nothing new
  always @(posedge sys_clk_i)
  begin
    busy_q <= busy_i;
    if (start_i)
    begin
      a_q <= addr_i;
      d_q <= wdata_i;
      m_q <= mode_i;
    end
    if (busy_q && !busy_i)
      mem[a_q] <= (m_q == 2'h0) ? d_q : (m_q == 2'h1) ? 8'hff
        : mem[a_q] & d_q;
  end
  // Garbage mid-programming, never the old byte
  assign rdata_o = busy_i ? ~mem[addr_i] : mem[addr_i];
endmodule : eac_nv_model
`default_nettype wire

//--- bench/eac_ctrl_test.sv
// Self-checking bench: registers, programming, refusals, resets.
// Assumes shortened programming counts; power-on reset drops once at start.
`timescale 1ns/100ps
`default_nettype none
module eac_ctrl_test;
  // Short counts keep the run brief, yet outlast the busy-time checks
  localparam int AC = 40;
  localparam int SC = 20;
  logic clk = 1'b0, nrst = 1'b0, tick = 1'b0, ds = 1'b0;
  logic wr = 1'b0, rd = 1'b0, bs = 1'b0, bc = 1'b0;
  logic gie = 1'b0, spa = 1'b0, rd_q = 1'b0, por = 1'b0;
  logic [2:0] bn = 3'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  logic [7:0] rdat, awd, ard;
  logic stall, irq, ast, abusy;
  logic [9:0] aa, a;
  logic [1:0] am, m;
  logic [7:0] d;
  logic [7:0] em [1024]; // Expected cells
  logic [7:0] expq [$]; // Noted read answers
  int n_fail = 0, checks_done = 0, seed = 13, k;
  eac_ctrl #(.ATOMIC_CYC(AC), .SPLIT_CYC(SC)) eac_ctrl_i (
    .sys_clk_i(clk), .nrst_i(nrst), .por_nrst_i(por),
    .rc_tick_i(tick), .cpu_addr_i(addr), .cpu_dspace_i(ds),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_bset_i(bs), .cpu_bclr_i(bc),
    .cpu_bit_i(bn), .cpu_wdata_i(wd), .cpu_rdata_o(rdat),
    .cpu_stall_o(stall), .global_irq_en_i(gie),
    .self_prog_active_i(spa), .ready_irq_o(irq), .arr_addr_o(aa),
    .arr_wdata_o(awd), .arr_mode_o(am), .arr_start_o(ast),
    .arr_busy_o(abusy), .arr_rdata_i(ard));
  eac_nv_model eac_nv_model_i (.sys_clk_i(clk), .addr_i(aa),
    .wdata_i(awd), .mode_i(am), .start_i(ast), .busy_i(abusy),
    .rdata_o(ard));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // Random oscillator ticks, off the sampling edge
  always @(negedge clk) tick <= 1'($random(seed));
  always @(posedge clk) rd_q <= rd;
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // Answer lands the edge after the read; oldest note is its match
  always @(negedge clk)
    if (rd_q) cmp(rdat, expq.pop_front());
  task automatic wreg(input logic [7:0] ad, dv, input logic s = 1'b0);
    while (stall) @(negedge clk);
    addr = ad;
    wd = dv;
    ds = s;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    ds = 1'b0;
    // Let an edge pass so a following call never retoggles the strobe
    @(negedge clk);
  endtask : wreg
  task automatic rreg(input logic [7:0] ad, e);
    while (stall) @(negedge clk);
    addr = ad;
    rd = 1'b1;
    expq.push_back(e);
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
  endtask : rreg
  task automatic bop(input logic s, input logic [7:0] ad, input logic [2:0] b);
    while (stall) @(negedge clk);
    addr = ad;
    bn = b;
    bs = s;
    bc = !s;
    @(negedge clk);
    bs = 1'b0;
    bc = 1'b0;
    @(negedge clk);
  endtask : bop
  // Address, data, arm, then strobe two edges after the arm
  task automatic prog(input logic [9:0] ad, input logic [7:0] dv,
    input logic [1:0] md);
    wreg(8'h21, ad[7:0]);
    wreg(8'h22, {6'h0, ad[9:8]});
    wreg(8'h20, dv);
    wreg(8'h1f, {2'h0, md, 4'h4});
    wreg(8'h1f, {2'h0, md, 4'h2});
  endtask : prog
  task automatic fetch(input logic [9:0] ad);
    while (abusy) @(negedge clk);
    wreg(8'h21, ad[7:0]);
    wreg(8'h22, {6'h0, ad[9:8]});
    wreg(8'h1f, 8'h01);
    rreg(8'h20, em[ad]);
  endtask : fetch
  task automatic idle();
    int i;
    for (i = 0; i < 400 && abusy === 1'b1; i++) @(negedge clk);
    cmp({7'h0, abusy}, 8'h00);
  endtask : idle
  task automatic rst_pulse();
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
  endtask : rst_pulse
  task automatic final_report();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Watchdog: the sequence needs well under a tenth of this
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
  initial
  begin
    foreach (em[i]) em[i] = 8'h00;
    repeat (20) @(negedge clk);
    por = 1'b1;
    nrst = 1'b1;
    rreg(8'h1f, 8'h00);
    wreg(8'h22, 8'hff);
    rreg(8'h22, 8'h03);
    wreg(8'h41, 8'h5a, 1'b1);
    rreg(8'h21, 8'h5a);
    rreg(8'h10, 8'h00);
    $display("test registers done");
    // Erase+write, erase and write at the top cell, then at random cells
    for (k = 0; k < 6; k++)
    begin
      a = (k < 3) ? 10'h3ff : 10'($random(seed));
      d = 8'($random(seed));
      m = 2'(k % 3);
      prog(a, d, m);
      wreg(8'h21, ~a[7:0]);
      wreg(8'h1f, {2'h0, ~m, 4'h1});
      rreg(8'h21, a[7:0]);
      rreg(8'h20, d);
      rreg(8'h1f, {2'h0, m, 4'h2});
      idle();
      em[a] = (m == 2'h0) ? d : (m == 2'h1) ? 8'hff : em[a] & d;
      rreg(8'h1f, {2'h0, m, 4'h0});
      fetch(a);
    end
    $display("test modes done");
    wreg(8'h1f, 8'h02);
    cmp({7'h0, abusy}, 8'h00);
    wreg(8'h1f, 8'h04);
    rreg(8'h1f, 8'h04);
    // Lands on the fourth edge, the last one that still sees arm
    rreg(8'h1f, 8'h04);
    wreg(8'h1f, 8'h02);
    cmp({7'h0, abusy}, 8'h00);
    rreg(8'h1f, 8'h00);
    prog(10'h3ff, 8'h77, 2'h3);
    cmp({7'h0, abusy}, 8'h00);
    fetch(10'h3ff);
    spa = 1'b1;
    prog(10'h3ff, 8'h77, 2'h0);
    cmp({7'h0, abusy}, 8'h00);
    wreg(8'h1f, 8'h08);
    gie = 1'b1;
    @(negedge clk);
    cmp({7'h0, irq}, 8'h00);
    spa = 1'b0;
    @(negedge clk);
    cmp({7'h0, irq}, 8'h01);
    $display("test refusals done");
    gie = 1'b0;
    prog(10'h001, 8'h96, 2'h0);
    gie = 1'b1;
    bop(1'b1, 8'h1f, 3'h3);
    cmp({7'h0, irq}, 8'h00);
    idle();
    em[1] = 8'h96;
    cmp({7'h0, irq}, 8'h01);
    rreg(8'h1f, 8'h08);
    wreg(8'h21, 8'h00);
    bop(1'b1, 8'h21, 3'h0);
    bop(1'b0, 8'h1f, 3'h3);
    rreg(8'h21, 8'h00);
    rreg(8'h1f, 8'h00);
    gie = 1'b0;
    fetch(10'h001);
    $display("test interrupt done");
    prog(10'h155, 8'h3c, 2'h1);
    rst_pulse();
    rreg(8'h1f, 8'h12);
    idle();
    em[10'h155] = 8'hff;
    rreg(8'h1f, 8'h10);
    fetch(10'h155);
    // Nonzero mode so an idle reset has something to clear
    wreg(8'h1f, 8'h20);
    rst_pulse();
    rreg(8'h1f, 8'h00);
    $display("test resets done");
    final_report();
  end
endmodule : eac_ctrl_test
`default_nettype wire
